// >>> hdl/bus_fault_classify_recover.sv
// Purpose: Bus fault classes, fault status word, frame contents and return rerun
// Assumes: Bus controller and sequencer share clk_i; fault pulse is synchronous
// Notes: Stack writing itself is done by the sequencer from the frame outputs
`timescale 1ns/1ps
// Function
// - Every bus fault falls in one of four classes.
// - Released write fault is taken at next boundary with next PC.
// - Operand access before the next boundary while released fault pends aborts and takes fault.
// - Released status word: rerun set, top bits and 8..6 zero.
// - Released frame holds next PC, status, fault address, write data.
// - Ordinary class covers prefetch, reads, locked, byte moves, except final writes.
// - Ordinary fault aborts now and restores auto-modified address registers.
// - Ordinary word clears trace, move, rerun; reports locked, fetch, read.
// - Ordinary word still captures both breakpoint pending bits.
// - Locked cycle sets locked flag; read flag shows failed half.
// - Move transfer faults own class; its prefetch faults are ordinary.
// - Move fault aborts without restoring any register.
// - Move word sets bit 14, clears bit 8, rerun for writes.
// - Fetch flag set when move restart refetch faults.
// - Move frame holds adjusted next address and count 16 minus attempts.
// - Second fault during fault exception halts with double fault.
// - Stacking fault writes fault frame with status, vector, return; PC only for six-word frame.
// - Return restores address, data, PC, status; requeues pending traps.
// - Unstacking tests only rerun; reloads read, space, size then reruns.
// - Rerun that became a read ignores its returned data.
// - Long operand fault in second access sets long flag and remaining size.
// - Rerun uses stacked address and size as found, even if edited.
// - Size codes: long 00, byte 01, word 10.
// - Read flag one for reads; space code copied from cycle.
// - Frame class 0 for operand faults, 1 for exception faults.
module bus_fault_classify_recover
    import fault_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic arst_n_i,
    // Faulted bus cycle from bus controller
    input wire logic bus_fault_signal_i,
    input wire logic cyc_read_i,
    input wire logic cyc_locked_i,
    input wire logic cyc_fetch_i,
    input wire logic cyc_released_i,
    input wire logic cyc_move_xfer_i,
    input wire logic cyc_move_restart_i,
    input wire logic cyc_long_second_i,
    input wire logic [1:0] cyc_size_i,
    input wire logic [2:0] space_code_lines_i,
    input wire logic [31:0] cyc_addr_i,
    input wire logic [15:0] cyc_wdata_i,
    input wire logic [1:0] cyc_op_size_i,
    input wire logic cyc_predec_i,
    input wire logic [4:0] move_attempts_i,
    // Processor context
    input wire logic in_exception_i,
    input wire logic in_fault_exception_i,
    input wire logic stack_frame_six_i,
    input wire logic boundary_i,
    input wire logic operand_req_i,
    input wire logic trace_pending_i,
    input wire logic ext_breakpoint_pending_i,
    input wire logic int_breakpoint_pending_i,
    input wire logic [31:0] next_pc_i,
    input wire logic [31:0] cur_pc_i,
    input wire logic [15:0] status_reg_i,
    input wire logic [15:0] vector_word_i,
    input wire logic [31:0] return_addr_i,
    input wire logic [31:0] cause_pc_i,
    // Exception return unstacking
    input wire logic ret_valid_i,
    input wire logic [15:0] ret_fsw_i,
    input wire logic [31:0] ret_addr_i,
    input wire logic [15:0] ret_data_i,
    input wire logic [31:0] ret_pc_i,
    input wire logic [15:0] ret_sr_i,
    input wire logic rerun_done_i,
    input wire logic rerun_rdata_valid_i,
    // Exception request and frame
    output logic take_fault_o,
    output logic abort_instr_o,
    output logic restore_regs_o,
    output logic halt_o,
    output logic [15:0] fault_status_word_o,
    output logic [31:0] frame_pc_o,
    output logic [15:0] frame_sr_o,
    output logic [31:0] frame_addr_o,
    output logic [15:0] frame_data_o,
    output logic [15:0] frame_vector_o,
    output logic [31:0] frame_cause_pc_o,
    output logic [4:0] frame_count_o,
    output logic frame_nested_o,
    // Return restore and rerun
    output logic restore_valid_o,
    output logic [31:0] restore_pc_o,
    output logic [15:0] restore_sr_o,
    output logic requeue_trace_o,
    output logic requeue_ext_bp_o,
    output logic requeue_int_bp_o,
    output logic rerun_req_o,
    output logic rerun_read_o,
    output logic [2:0] rerun_space_o,
    output logic [1:0] rerun_size_o,
    output logic [31:0] rerun_addr_o,
    output logic [15:0] rerun_wdata_o,
    output logic rerun_rdata_accept_o
);
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_PEND = 3'b010,
        ST_HALT = 3'b100
    } fault_state_e;

    fault_state_e state_q;
    fault_class_e cls;
    logic pend_fire;
    logic rerun_busy_q;
    logic rerun_is_read_q;
    logic [15:0] fsw_d;

    function automatic logic [31:0] size_bytes(input logic [1:0] sz);
        unique case (sz)
            SIZE_BYTE: size_bytes = 32'h00000001;
            SIZE_WORD: size_bytes = 32'h00000002;
            default: size_bytes = 32'h00000004;
        endcase
    endfunction

    fault_classifier u_cls (
        .released_i(cyc_released_i),
        .in_exception_i(in_exception_i),
        .move_xfer_i(cyc_move_xfer_i),
        .class_o(cls)
    );

    // Status word build
    always_comb begin
        fsw_d = FSW_RESET;
        fsw_d[FSW_EXTBP_BIT] = ext_breakpoint_pending_i;
        fsw_d[FSW_INTBP_BIT] = int_breakpoint_pending_i;
        fsw_d[FSW_LONG_BIT] = cyc_long_second_i;
        fsw_d[FSW_SIZE_LSB +: 2] = cyc_size_i;
        fsw_d[FSW_SPACE_LSB +: 3] = space_code_lines_i;
        unique case (cls)
            CLS_RELEASED: begin
                fsw_d[FSW_TRACE_BIT] = trace_pending_i;
                fsw_d[FSW_RERUN_BIT] = 1'b1;
            end
            CLS_ORDINARY: begin
                fsw_d[FSW_LOCKED_BIT] = cyc_locked_i;
                fsw_d[FSW_FETCH_BIT] = cyc_fetch_i;
                fsw_d[FSW_READ_BIT] = cyc_read_i;
            end
            CLS_MOVE: begin
                fsw_d[FSW_MOVE_BIT] = 1'b1;
                fsw_d[FSW_TRACE_BIT] = trace_pending_i;
                fsw_d[FSW_RERUN_BIT] = ~cyc_read_i;
                fsw_d[FSW_FETCH_BIT] = cyc_move_restart_i & cyc_fetch_i;
                fsw_d[FSW_READ_BIT] = cyc_read_i;
            end
            CLS_EXCEPTION: begin
                fsw_d[FSW_CLASS_BIT] = 1'b1;
                fsw_d[FSW_TRACE_BIT] = trace_pending_i;
                fsw_d[FSW_READ_BIT] = cyc_read_i;
            end
        endcase
    end

    assign pend_fire = (state_q == ST_PEND) && (boundary_i || operand_req_i);

    // Released write pending and double fault
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state_q <= ST_IDLE;
        end else begin
            unique case (state_q)
                ST_IDLE: begin
                    if (bus_fault_signal_i && in_fault_exception_i) begin
                        state_q <= ST_HALT;
                    end else if (bus_fault_signal_i && cls == CLS_RELEASED) begin
                        state_q <= ST_PEND;
                    end
                end
                ST_PEND: begin
                    if (pend_fire) begin
                        state_q <= ST_IDLE;
                    end
                end
                ST_HALT: state_q <= ST_HALT;
            endcase
        end
    end

    // Fault frame capture
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            take_fault_o <= 1'b0;
            abort_instr_o <= 1'b0;
            restore_regs_o <= 1'b0;
            fault_status_word_o <= FSW_RESET;
            frame_pc_o <= ADDR_RESET;
            frame_sr_o <= FSW_RESET;
            frame_addr_o <= ADDR_RESET;
            frame_data_o <= FSW_RESET;
            frame_vector_o <= FSW_RESET;
            frame_cause_pc_o <= ADDR_RESET;
            frame_count_o <= 5'h00;
            frame_nested_o <= 1'b0;
        end else begin
            take_fault_o <= 1'b0;
            abort_instr_o <= 1'b0;
            restore_regs_o <= 1'b0;
            if (pend_fire) begin
                take_fault_o <= 1'b1;
                abort_instr_o <= operand_req_i && !boundary_i;
                frame_pc_o <= next_pc_i;
                frame_sr_o <= status_reg_i;
            end
            if (bus_fault_signal_i && state_q == ST_IDLE && !in_fault_exception_i) begin
                fault_status_word_o <= fsw_d;
                frame_addr_o <= cyc_addr_i;
                frame_sr_o <= status_reg_i;
                frame_nested_o <= 1'b0;
                unique case (cls)
                    CLS_RELEASED: begin
                        frame_data_o <= cyc_wdata_i;
                    end
                    CLS_ORDINARY: begin
                        take_fault_o <= 1'b1;
                        abort_instr_o <= 1'b1;
                        restore_regs_o <= 1'b1;
                        frame_pc_o <= cur_pc_i;
                    end
                    CLS_MOVE: begin
                        take_fault_o <= 1'b1;
                        abort_instr_o <= 1'b1;
                        frame_pc_o <= cur_pc_i;
                        frame_addr_o <= cyc_predec_i ? cyc_addr_i - size_bytes(cyc_op_size_i)
                            : cyc_addr_i + size_bytes(cyc_op_size_i);
                        frame_count_o <= MOVE_SLOTS - move_attempts_i;
                        frame_data_o <= cyc_wdata_i;
                    end
                    CLS_EXCEPTION: begin
                        take_fault_o <= 1'b1;
                        frame_nested_o <= 1'b1;
                        frame_pc_o <= return_addr_i;
                        frame_vector_o <= vector_word_i;
                        frame_cause_pc_o <= stack_frame_six_i ? cause_pc_i : ADDR_RESET;
                    end
                endcase
            end
        end
    end

    assign halt_o = (state_q == ST_HALT);

    // Exception return restore and rerun
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            restore_valid_o <= 1'b0;
            restore_pc_o <= ADDR_RESET;
            restore_sr_o <= FSW_RESET;
            requeue_trace_o <= 1'b0;
            requeue_ext_bp_o <= 1'b0;
            requeue_int_bp_o <= 1'b0;
            rerun_busy_q <= 1'b0;
            rerun_is_read_q <= 1'b0;
            rerun_read_o <= 1'b0;
            rerun_space_o <= 3'h0;
            rerun_size_o <= SIZE_LONG;
            rerun_addr_o <= ADDR_RESET;
            rerun_wdata_o <= FSW_RESET;
        end else begin
            restore_valid_o <= 1'b0;
            requeue_trace_o <= 1'b0;
            requeue_ext_bp_o <= 1'b0;
            requeue_int_bp_o <= 1'b0;
            if (ret_valid_i && !rerun_busy_q) begin
                restore_valid_o <= 1'b1;
                restore_pc_o <= ret_pc_i;
                restore_sr_o <= ret_sr_i;
                requeue_trace_o <= ret_fsw_i[FSW_TRACE_BIT];
                requeue_ext_bp_o <= ret_fsw_i[FSW_EXTBP_BIT];
                requeue_int_bp_o <= ret_fsw_i[FSW_INTBP_BIT];
                rerun_addr_o <= ret_addr_i;
                rerun_wdata_o <= ret_data_i;
                if (ret_fsw_i[FSW_RERUN_BIT]) begin
                    rerun_busy_q <= 1'b1;
                    rerun_read_o <= ret_fsw_i[FSW_READ_BIT];
                    rerun_is_read_q <= ret_fsw_i[FSW_READ_BIT];
                    rerun_space_o <= ret_fsw_i[FSW_SPACE_LSB +: 3];
                    rerun_size_o <= ret_fsw_i[FSW_SIZE_LSB +: 2];
                end
            end else if (rerun_busy_q && rerun_done_i) begin
                rerun_busy_q <= 1'b0;
                rerun_is_read_q <= 1'b0;
            end
        end
    end

    assign rerun_req_o = rerun_busy_q;
    assign rerun_rdata_accept_o = rerun_busy_q && !rerun_is_read_q && rerun_rdata_valid_i;

    property p_released_waits;
        @(posedge clk_i) disable iff (!arst_n_i)
        (state_q == ST_PEND && !boundary_i && !operand_req_i) |=> !take_fault_o;
    endproperty
    a_released_waits: assert property (p_released_waits) else $error("released fault taken early");
    property p_released_taken;
        @(posedge clk_i) disable iff (!arst_n_i)
        pend_fire |=> take_fault_o && frame_pc_o == $past(next_pc_i);
    endproperty
    a_released_taken: assert property (p_released_taken) else $error("released fault not taken");
    property p_operand_abort;
        @(posedge clk_i) disable iff (!arst_n_i)
        (pend_fire && operand_req_i && !boundary_i) |=> abort_instr_o;
    endproperty
    a_operand_abort: assert property (p_operand_abort) else $error("operand access not aborted");
    property p_released_word;
        @(posedge clk_i) disable iff (!arst_n_i)
        (bus_fault_signal_i && state_q == ST_IDLE && !in_fault_exception_i && cls == CLS_RELEASED)
        |=> fault_status_word_o[15:13] == 3'h0 && fault_status_word_o[9] && fault_status_word_o[8:6] == 3'h0;
    endproperty
    a_released_word: assert property (p_released_word) else $error("released status word wrong");
    property p_ordinary_word;
        @(posedge clk_i) disable iff (!arst_n_i)
        (bus_fault_signal_i && state_q == ST_IDLE && !in_fault_exception_i && cls == CLS_ORDINARY)
        |=> fault_status_word_o[12] == 1'b0 && fault_status_word_o[14] == 1'b0 && fault_status_word_o[9] == 1'b0
            && fault_status_word_o[8] == $past(cyc_locked_i) && fault_status_word_o[6] == $past(cyc_read_i);
    endproperty
    a_ordinary_word: assert property (p_ordinary_word) else $error("ordinary status word wrong");
    property p_move_word;
        @(posedge clk_i) disable iff (!arst_n_i)
        (bus_fault_signal_i && state_q == ST_IDLE && !in_fault_exception_i && cls == CLS_MOVE)
        |=> fault_status_word_o[14] && !fault_status_word_o[8]
            && fault_status_word_o[9] == !$past(cyc_read_i) && frame_count_o == MOVE_SLOTS - $past(move_attempts_i);
    endproperty
    a_move_word: assert property (p_move_word) else $error("move status word wrong");
    sequence s_double_fault;
        bus_fault_signal_i && in_fault_exception_i && state_q == ST_IDLE;
    endsequence
    property p_double_halt;
        @(posedge clk_i) disable iff (!arst_n_i)
        s_double_fault |=> halt_o [*3];
    endproperty
    a_double_halt: assert property (p_double_halt) else $error("double fault did not halt");
    sequence s_rerun_start;
        ret_valid_i && !rerun_busy_q && ret_fsw_i[9];
    endsequence
    property p_rerun_load;
        @(posedge clk_i) disable iff (!arst_n_i)
        s_rerun_start |=> rerun_req_o && rerun_read_o == $past(ret_fsw_i[6])
            && rerun_size_o == $past(ret_fsw_i[4:3]) && rerun_addr_o == $past(ret_addr_i);
    endproperty
    a_rerun_load: assert property (p_rerun_load) else $error("rerun not loaded from stack");
    property p_read_ignored;
        @(posedge clk_i) disable iff (!arst_n_i)
        (rerun_busy_q && rerun_is_read_q) |-> !rerun_rdata_accept_o;
    endproperty
    a_read_ignored: assert property (p_read_ignored) else $error("rerun read data accepted");
    property p_exception_class;
        @(posedge clk_i) disable iff (!arst_n_i)
        (bus_fault_signal_i && state_q == ST_IDLE && !in_fault_exception_i)
        |=> fault_status_word_o[15] == $past(in_exception_i);
    endproperty
    a_exception_class: assert property (p_exception_class) else $error("frame class bit wrong");
endmodule

// >>> hdl/fault_pkg.sv
// Purpose: Shared constants for bus fault classification and recovery
// Assumes: 16-bit fault status word, 3-bit space code
// Notes: Bit numbers are positions in the fault status word
package fault_pkg;
    localparam int FSW_W = 16;
    localparam int FSW_CLASS_BIT = 15;
    localparam int FSW_MOVE_BIT = 14;
    localparam int FSW_TRACE_BIT = 12;
    localparam int FSW_EXTBP_BIT = 11;
    localparam int FSW_INTBP_BIT = 10;
    localparam int FSW_RERUN_BIT = 9;
    localparam int FSW_LOCKED_BIT = 8;
    localparam int FSW_FETCH_BIT = 7;
    localparam int FSW_READ_BIT = 6;
    localparam int FSW_LONG_BIT = 5;
    localparam int FSW_SIZE_LSB = 3;
    localparam int FSW_SPACE_LSB = 0;
    localparam logic [1:0] SIZE_LONG = 2'h0;
    localparam logic [1:0] SIZE_BYTE = 2'h1;
    localparam logic [1:0] SIZE_WORD = 2'h2;
    localparam logic [4:0] MOVE_SLOTS = 5'h10;
    localparam logic [15:0] FSW_RESET = 16'h0000;
    localparam logic [31:0] ADDR_RESET = 32'h00000000;
    typedef enum logic [1:0] {
        CLS_RELEASED = 2'h0,
        CLS_ORDINARY = 2'h1,
        CLS_MOVE = 2'h2,
        CLS_EXCEPTION = 2'h3
    } fault_class_e;
endpackage

// >>> hdl/fault_classifier.sv
// Purpose: Sorts a faulted bus cycle into one of four classes
// Assumes: Inputs are same-clock status from the bus controller
// Notes: Purely combinational
`timescale 1ns/1ps
module fault_classifier
    import fault_pkg::*;
(
    // Cycle attributes
    input wire logic released_i,
    input wire logic in_exception_i,
    input wire logic move_xfer_i,
    // Result
    output fault_class_e class_o
);
    always_comb begin
        if (in_exception_i) begin
            class_o = CLS_EXCEPTION;
        end else if (released_i) begin
            class_o = CLS_RELEASED;
        end else if (move_xfer_i) begin
            class_o = CLS_MOVE;
        end else begin
            class_o = CLS_ORDINARY;
        end
    end
endmodule

// >>> tb/rerun_bus_model.sv
// Purpose: Bus controller model that completes rerun cycles
// Assumes: Rerun request stays high until the end pulse has been seen
// Notes: Delay input selects prompt or slow completion
`timescale 1ns/1ps
module rerun_bus_model (
    // Clock and reset
    input wire logic clk_i,
    input wire logic arst_n_i,
    // Rerun request
    input wire logic rerun_req_i,
    input wire logic rerun_read_i,
    input wire logic [3:0] delay_i,
    // Completion
    output logic rerun_done_o,
    output logic rerun_rdata_valid_o
);
    logic [3:0] cnt_q;
    logic busy_q;
    logic spent_q;

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cnt_q <= 4'h0;
            busy_q <= 1'h0;
            spent_q <= 1'h0;
            rerun_done_o <= 1'h0;
            rerun_rdata_valid_o <= 1'h0;
        end else begin
            rerun_done_o <= 1'h0;
            rerun_rdata_valid_o <= 1'h0;
            if (spent_q) begin
                // Wait for the request to drop before taking another
                spent_q <= rerun_req_i;
            end else if (!busy_q && rerun_req_i) begin
                busy_q <= 1'h1;
                cnt_q <= delay_i;
            end else if (busy_q && cnt_q != 4'h0) begin
                cnt_q <= cnt_q - 4'h1;
            end else if (busy_q) begin
                busy_q <= 1'h0;
                spent_q <= 1'h1;
                rerun_done_o <= 1'h1;
                // Read data returns even though the device must drop it
                rerun_rdata_valid_o <= rerun_read_i;
            end
        end
    end
endmodule

// >>> tb/testbench.sv
// Purpose: Self-checking bench for fault classes, status word, frames and rerun
// Assumes: Inputs change 1 ns after the rising edge
// Notes: Class cases as table rows, return and halt cases by hand
`timescale 1ns/1ps
module testbench;
    import fault_pkg::*;
    typedef struct packed {
        logic [1:0] k;
        logic [4:0] f;
        logic [1:0] sz;
        logic [2:0] sp;
        logic [3:0] p;
        logic [15:0] fsw;
        logic [15:0] mask;
    } row_s;
    // Class: 0 released, 1 ordinary, 2 move, 3 exception; f: rd lk fe rs lg; p: tr b1 b0 pd
    row_s rows [0:6] = '{'{2'h1, 5'h14, 2'h2, 3'h6, 4'hC, 16'h08D6, 16'hFFFF},
        '{2'h1, 5'h09, 2'h1, 3'h5, 4'h2, 16'h052D, 16'hFFFF}, '{2'h1, 5'h19, 2'h0, 3'h1, 4'h0, 16'h0161, 16'hFFFF},
        '{2'h2, 5'h00, 2'h2, 3'h1, 4'hF, 16'h5E11, 16'hFFFF}, '{2'h2, 5'h16, 2'h2, 3'h6, 4'h0, 16'h40D6, 16'hFFFF},
        '{2'h3, 5'h10, 2'h0, 3'h5, 4'hA, 16'h9400, 16'h9C00}, '{2'h0, 5'h01, 2'h1, 3'h1, 4'hC, 16'h1A29, 16'hFFFF}};
    logic clk, arst_n, fault, rd, lk, fe, rs, lgs, pd, rel, mvx, inx, infx, bnd, opr, tr, b1, b0, retv, done, rdv;
    logic six = 1'h1;
    logic [1:0] sz;
    logic [2:0] sp;
    logic [3:0] dly;
    logic [4:0] att = 5'h05;
    logic [31:0] addr, inc, npc = 32'h00002000, cur = 32'h00001FFC, ra = 32'h00004000, cz = 32'h00001FF0;
    logic [31:0] rpc = 32'h00005000, rad = 32'h00003FFE;
    logic [15:0] wd, rfsw, sr = 16'h2700, vec = 16'h2018, rdat = 16'hBEEF, rsi = 16'h0704;
    logic take, abrt, rstr, halt, nest, rval, rq_t, rq_e, rq_i, rr, rrd, acc;
    logic [15:0] fsw, fsr, fdat, fvec, rsr, rwd;
    logic [31:0] fpc, faddr, fcpc, rspc, raddr;
    logic [4:0] fcnt;
    logic [2:0] rspace;
    logic [1:0] rsize;
    row_s r;
    int errors, n_tests, n;

    bus_fault_classify_recover i_dut (.clk_i(clk), .arst_n_i(arst_n), .bus_fault_signal_i(fault), .cyc_read_i(rd),
        .cyc_locked_i(lk), .cyc_fetch_i(fe), .cyc_released_i(rel), .cyc_move_xfer_i(mvx), .cyc_move_restart_i(rs),
        .cyc_long_second_i(lgs), .cyc_size_i(sz), .space_code_lines_i(sp), .cyc_addr_i(addr), .cyc_wdata_i(wd),
        .cyc_op_size_i(sz), .cyc_predec_i(pd), .move_attempts_i(att), .in_exception_i(inx),
        .in_fault_exception_i(infx), .stack_frame_six_i(six), .boundary_i(bnd), .operand_req_i(opr),
        .trace_pending_i(tr), .ext_breakpoint_pending_i(b1), .int_breakpoint_pending_i(b0), .next_pc_i(npc),
        .cur_pc_i(cur), .status_reg_i(sr), .vector_word_i(vec), .return_addr_i(ra), .cause_pc_i(cz),
        .ret_valid_i(retv), .ret_fsw_i(rfsw), .ret_addr_i(rad), .ret_data_i(rdat), .ret_pc_i(rpc), .ret_sr_i(rsi),
        .rerun_done_i(done), .rerun_rdata_valid_i(rdv), .take_fault_o(take), .abort_instr_o(abrt),
        .restore_regs_o(rstr), .halt_o(halt), .fault_status_word_o(fsw), .frame_pc_o(fpc), .frame_sr_o(fsr),
        .frame_addr_o(faddr), .frame_data_o(fdat), .frame_vector_o(fvec), .frame_cause_pc_o(fcpc),
        .frame_count_o(fcnt), .frame_nested_o(nest), .restore_valid_o(rval), .restore_pc_o(rspc),
        .restore_sr_o(rsr), .requeue_trace_o(rq_t), .requeue_ext_bp_o(rq_e), .requeue_int_bp_o(rq_i),
        .rerun_req_o(rr), .rerun_read_o(rrd), .rerun_space_o(rspace), .rerun_size_o(rsize), .rerun_addr_o(raddr),
        .rerun_wdata_o(rwd), .rerun_rdata_accept_o(acc));

    rerun_bus_model i_bus (.clk_i(clk), .arst_n_i(arst_n), .rerun_req_i(rr), .rerun_read_i(rrd), .delay_i(dly),
        .rerun_done_o(done), .rerun_rdata_valid_o(rdv));

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic tick();
        @(posedge clk);
        #1;
    endtask

    task automatic pulse_fault();
        fault = 1'h1;
        tick();
        fault = 1'h0;
    endtask

    task automatic ret_frame(input logic [15:0] v);
        rfsw = v;
        retv = 1'h1;
        tick();
        retv = 1'h0;
    endtask

    task automatic end_of_test();
        if (errors == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    initial begin
        clk = 1'h0;
        forever #5 clk = ~clk;
    end

    always @(negedge clk) begin
        if (rdv === 1'h1) begin
            check("rdata_accept", acc, 32'h0);
        end
    end

    initial begin
        #100000;
        errors++;
        end_of_test();
    end

    initial begin
        arst_n = 1'h0;
        {fault, rd, lk, fe, rs, lgs, pd, rel, mvx, inx, infx, bnd, opr, tr, b1, b0, retv, sz, sp, dly} = '0;
        addr = 32'h00001230;
        wd = 16'h0000;
        rfsw = 16'h0000;
        repeat (16) @(posedge clk);
        #1;
        arst_n = 1'h1;
        tick();
        foreach (rows[i]) begin
            r = rows[i];
            {rd, lk, fe, rs, lgs} = r.f;
            {tr, b1, b0, pd} = r.p;
            sz = r.sz;
            sp = r.sp;
            rel = (r.k == 2'h0);
            mvx = (r.k == 2'h2);
            inx = (r.k == 2'h3);
            addr = 32'h00001230 + 32'(i * 16);
            wd = 16'hA5C3 ^ 16'(i);
            inc = (sz == SIZE_LONG) ? 32'h4 : {30'h0, sz};
            pulse_fault();
            if (rel) begin
                tick();
                bnd = 1'h1;
                tick();
                bnd = 1'h0;
            end
            check("take", take, 32'h1);
            check("fsw", fsw & r.mask, r.fsw);
            check("restore_regs", rstr, r.k == 2'h1);
            check("abort", abrt, r.k == 2'h1 || r.k == 2'h2);
            check("nested", nest, r.k == 2'h3);
            check("frame_sr", fsr, sr);
            check("frame_pc", fpc, (r.k == 2'h0) ? npc : (r.k == 2'h3) ? ra : cur);
            if (r.k == 2'h0) begin
                check("frame_addr", faddr, addr);
                check("frame_data", fdat, wd);
            end
            if (r.k == 2'h2) begin
                check("move_addr", faddr, pd ? addr - inc : addr + inc);
                check("move_count", fcnt, MOVE_SLOTS - att);
            end
            if (r.k == 2'h3) begin
                check("frame_vector", fvec, vec);
                check("frame_cause_pc", fcpc, cz);
            end
            repeat (2) tick();
        end
        // Operand access while a released fault waits
        {rel, mvx, inx, rd, tr, b1, b0} = 7'h40;
        pulse_fault();
        tick();
        opr = 1'h1;
        tick();
        opr = 1'h0;
        check("take_on_operand", take, 32'h1);
        check("abort_on_operand", abrt, 32'h1);
        rel = 1'h0;
        repeat (2) tick();
        // Slow rerun of an edited released write
        dly = 4'h3;
        ret_frame(16'h1615);
        check("restore_valid", rval, 32'h1);
        check("restore_pc", rspc, rpc);
        check("restore_sr", rsr, rsi);
        check("requeue", {rq_t, rq_e, rq_i}, 32'h5);
        check("rerun_req", rr, 32'h1);
        check("rerun_ctl", {rrd, rspace, rsize}, 32'h16);
        check("rerun_addr", raddr, rad);
        check("rerun_data", rwd, rdat);
        n = 0;
        while (rr === 1'h1 && n < 20) begin
            tick();
            n++;
        end
        check("rerun_end", rr, 32'h0);
        // Prompt rerun that became a read
        dly = 4'h0;
        ret_frame(16'h0241);
        check("rerun_read", {rr, rrd}, 32'h3);
        repeat (6) tick();
        // Control bits set but no rerun flag
        ret_frame(16'h01C0);
        check("restore_only", rval, 32'h1);
        check("no_rerun", rr, 32'h0);
        repeat (2) tick();
        // Second fault while handling a fault
        infx = 1'h1;
        pulse_fault();
        check("no_take_double", take, 32'h0);
        repeat (3) tick();
        check("halt", halt, 32'h1);
        infx = 1'h0;
        arst_n = 1'h0;
        tick();
        check("reset_out", {halt, take, rr, fsw}, 32'h0);
        arst_n = 1'h1;
        repeat (2) tick();
        check("halt_cleared", halt, 32'h0);
        end_of_test();
    end
endmodule
